/* hdl/dwl_training.sv */
`timescale 1ns/1ns
// How it works
// (RULE1) MR1 write with A7 high enters leveling, A7 low leaves it.
// (RULE2) MR1 A12 high disables data outputs, low enables them.
// (RULE3) In leveling, ODT switches strobe termination only; data termination off.
// (RULE4) Controller uses RZQ/2, /4 or /6 termination when outputs enabled.
// (RULE5) Controller issues only NOP/deselect or MR1 writes while leveling.
// (RULE6) Exiting MR1 write may also change A12, A9, A6, A5, A2, A1.
// (RULE7) Controller levels one rank, disabling outputs of all others.
// (RULE8) ODT is accepted only after the mode register delay from entry.
// (RULE9) Strobe termination is on once ODT is accepted and asserted.
// (RULE10) Controller sends one rising strobe edge after low time.
// (RULE11) Each rising strobe edge samples CK; level appears on data lines.
// (RULE12) Feedback on one prime bit or all bits; others held low.
// (RULE13) Each byte lane has its own strobe and its own feedback.
// (RULE14) Controller steps strobe delay and locks on 0 to 1 change.
// (RULE15) After exit, data lines float until the mode register delay ends.
// (RULE16) Controller waits mode register delay after exit before commands.
// (RULE17) MR3 A2 high enables the calibration register.
// (RULE18) Calibration mode redirects reads; MR3 A[1:0] picks location.
// (RULE19) Only reads allowed in calibration mode; others flagged. Code also lets MRS and NOP through unflagged.
// (RULE20) Read with auto precharge acts as a plain read there.
// (RULE21) Calibration bit on lane bit 0; bits 7:1 copy or zero.
// (RULE22) Column A2 picks nibble order for chopped bursts; BL8 fixed.
// (RULE23) Normal read latency applies; other address bits ignored.
// (RULE24) Location 00 gives pattern 0,1,0,1; other locations read zero.
// (RULE25) Controller waits recovery time after last calibration read.
// (RULE26) Captured CK level holds until next strobe edge or exit.
module dwl_training
  import dwl_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ck,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  input  wire logic        odt,
  input  wire logic        lower_lane_strobe_pair,
  input  wire logic        upper_lane_strobe_pair,
  output logic      [7:0]  lower_byte_data_lines,
  output logic             lower_byte_data_oe,
  output logic      [7:0]  upper_byte_data_lines,
  output logic             upper_byte_data_oe,
  output logic      [1:0]  strobe_term_on,
  output logic             data_term_on
);
  import dwl_pkg::*;

  logic             rst_m;
  logic             rst_s_n;
  logic [24:0]      pins_s;
  logic             ck_s;
  logic             ck_d;
  logic             odt_s;
  logic [1:0]       strb_s;
  logic [1:0]       strb_d;
  logic [2:0]       cmd_s;
  logic             cs_s_n;
  logic [2:0]       ba_s;
  logic [13:0]      addr_s;
  logic             ck_rise;
  logic             ck_edge;
  logic             cmd_mrs;
  logic             cmd_rd;
  logic [13:0]      mr1;
  logic [13:0]      mr3;
  logic [1:0]       mr0_bl;
  logic             wl_mode;
  logic             mpr_en;
  logic [4:0]       mod_cnt;
  logic             mod_busy;
  logic [7:0]       ctrl;
  logic             ill_cmd;
  logic [1:0]       fb;
  logic [1:0]       fb_seen;
  logic [1:0]       fb_out;
  logic [7:0]       dq_q [2];
  logic [1:0]       dq_oe;
  dwl_state_t       state;
  logic [3:0]       rl_cnt;
  logic [2:0]       beat;
  logic [3:0]       beats_left;
  logic             mpr_bit;
  logic             chop;
  logic             wr_en;
  logic             stat_hit;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m   <= 1'b0;
      rst_s_n <= 1'b0;
    end else begin
      rst_m   <= 1'b1;
      rst_s_n <= rst_m;
    end
  end

  // All DRAM pins come from the controller's domain
  dwl_sync #(.W(25)) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_s_n),
    .d       ({ck, odt, upper_lane_strobe_pair, lower_lane_strobe_pair,
                cs_n, ras_n, cas_n, we_n, ba, addr}),
    .q       (pins_s)
  );

  assign {ck_s, odt_s, strb_s, cs_s_n, cmd_s, ba_s, addr_s} = pins_s;

  // Edge history; CK is slow so one flop is plenty
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ck_d   <= 1'b0;
      strb_d <= 2'h0;
    end else begin
      ck_d   <= ck_s;
      strb_d <= strb_s;
    end
  end

  assign ck_rise = ck_s & ~ck_d;
  assign ck_edge = ck_s ^ ck_d;
  // Commands settle long before CK rises, so the synced copy is safe
  assign cmd_mrs = ck_rise & ~cs_s_n & (cmd_s == CMD_MRS);
  assign cmd_rd  = ck_rise & ~cs_s_n & (cmd_s == CMD_RD);  // A10 ignored [RULE20]
  assign wl_mode = mr1[MR1_WL];
  assign mpr_en  = mr3[MR3_MPR];

  // Mode registers; exit write keeps every field it carries [RULE6]
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      mr1    <= '0;
      mr3    <= '0;
      mr0_bl <= BL_FIX8;
    end else if (cmd_mrs) begin
      if (ba_s == BA_MR1) begin
        mr1 <= addr_s;  // A7 enters or leaves, A12 gates outputs [RULE1] [RULE2]
      end
      if (ba_s == BA_MR3) begin
        mr3 <= addr_s;  // Banks assumed idle by the controller [RULE17] [RULE18]
      end
      if (ba_s == BA_MR0) begin
        mr0_bl <= addr_s[1:0];
      end
    end
  end

  // Mode register delay, counted in CK cycles from any MRS except an MR1 write with A7 high while leveling
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      mod_cnt <= '0;
    end else if (cmd_mrs && !(wl_mode && ba_s == BA_MR1 && addr_s[MR1_WL])) begin
      mod_cnt <= TMOD_CK;  // Output toggles keep ODT accepted [RULE8] [RULE15]
    end else if (ck_rise && mod_busy) begin
      mod_cnt <= mod_cnt - 5'h01;
    end
  end

  assign mod_busy = (mod_cnt != 5'h00);

  // Termination; in leveling ODT ignored until the delay has run [RULE8] [RULE9]
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      strobe_term_on <= 2'h0;
      data_term_on   <= 1'b0;
    end else begin
      strobe_term_on <= {2{odt_s & (~wl_mode | ~mod_busy)}};
      data_term_on   <= odt_s & ~wl_mode;  // Off in leveling [RULE3]
    end
  end

  // Commands other than reads, MRS or NOP while calibrating are flagged
  assign wr_en    = psel & penable & pwrite;
  assign stat_hit = wr_en & (paddr == STAT_ADDR);
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ill_cmd <= 1'b0;
    end else if (ck_rise && !cs_s_n && mpr_en && cmd_s != CMD_RD
                 && cmd_s != CMD_MRS && cmd_s != CMD_NOP) begin
      ill_cmd <= 1'b1;  // Set beats a same-cycle clear [RULE19]
    end else if (stat_hit && pwdata[ST_ILL]) begin
      ill_cmd <= 1'b0;
    end
  end

  // Chop from MR0 or on the fly through A12
  assign chop = (mr0_bl == BL_BC4) | ((mr0_bl == BL_OTF) & ~addr_s[ADDR_BC]);

  // Calibration read sequencer; reads while busy are dropped
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state      <= DWL_IDLE;
      rl_cnt     <= '0;
      beat       <= '0;
      beats_left <= '0;
    end else begin
      unique case (state)
        DWL_IDLE: begin
          if (cmd_rd && mpr_en) begin
            state      <= DWL_WAIT;  // [RULE18] [RULE20]
            rl_cnt     <= ctrl[CTRL_RL_LSB +: 4];  // Normal latency [RULE23]
            beat       <= {chop & addr_s[2], 2'h0};  // Nibble order [RULE22]
            beats_left <= chop ? BEATS4 : BEATS8;
          end
        end
        DWL_WAIT: begin
          if (ck_rise) begin
            rl_cnt <= rl_cnt - 4'h1;
            if (rl_cnt <= 4'h1) begin
              state <= DWL_BURST;
            end
          end
        end
        DWL_BURST: begin
          if (ck_edge) begin
            beat       <= beat + 3'h1;
            beats_left <= beats_left - 4'h1;
            if (beats_left == 4'h1) begin
              state <= DWL_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Pattern bit per beat; reserved locations read zero
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      mpr_bit <= 1'b0;
    end else begin
      mpr_bit <= (state == DWL_BURST) & (mr3[1:0] == LOC_PAT) & beat[0];  // [RULE24]
    end
  end

  // One capture and drive path per byte lane [RULE13]
  for (genvar i = 0; i < 2; i++) begin : g_lane
    logic [TWLO_CYC:0] pipe;

    // Catch CK on strobe rise, hold until next rise or exit [RULE11] [RULE26]
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
        fb[i]      <= 1'b0;
        fb_seen[i] <= 1'b0;
      end else if (!wl_mode) begin
        fb[i]      <= 1'b0;
        fb_seen[i] <= 1'b0;
      end else if (strb_s[i] && !strb_d[i]) begin
        fb[i]      <= ck_s;
        fb_seen[i] <= 1'b1;
      end
    end

    // Output delay of the feedback, no read strobe involved
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
        pipe <= '0;
      end else begin
        pipe <= {pipe[TWLO_CYC-1:0], fb[i]};  // [RULE11]
      end
    end

    assign fb_out[i] = pipe[TWLO_CYC];

    // Lane drive: leveling feedback or calibration data
    always_ff @(posedge ref_clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
        dq_q[i]  <= 8'h00;
        dq_oe[i] <= 1'b0;
      end else if (wl_mode) begin
        dq_oe[i] <= ~mr1[MR1_QOFF];  // [RULE2]
        dq_q[i]  <= ctrl[CTRL_FB_ALL] ? {8{fb_out[i]}}
                                      : {7'h00, fb_out[i]};  // [RULE12]
      end else if (state == DWL_BURST) begin
        dq_oe[i] <= ~mr1[MR1_QOFF];
        dq_q[i]  <= ctrl[CTRL_COPY] ? {8{mpr_bit}}
                                    : {7'h00, mpr_bit};  // [RULE21]
      end else begin
        dq_oe[i] <= 1'b0;  // Floats after exit until delay ends [RULE15]
        dq_q[i]  <= 8'h00;
      end
    end
  end

  assign lower_byte_data_lines = dq_q[0];
  assign upper_byte_data_lines = dq_q[1];
  assign lower_byte_data_oe    = dq_oe[0];
  assign upper_byte_data_oe    = dq_oe[1];

  // Control register
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ctrl <= CTRL_RST;
    end else if (wr_en && paddr == CTRL_ADDR) begin
      ctrl <= pwdata[7:0];
    end
  end

  // Read data is latched in the setup phase, so no wait states
  always_ff @(posedge ref_clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      prdata <= '0;
    end else if (psel && !penable) begin
      unique case (paddr)
        CTRL_ADDR: prdata <= {24'h000000, ctrl};
        STAT_ADDR: prdata <= {24'h000000, state != DWL_IDLE, ill_cmd, fb_out,
                              wl_mode & ~mod_busy, mpr_en, mr1[MR1_QOFF], wl_mode};
        MR1_ADDR:  prdata <= {18'h00000, mr1};
        MR3_ADDR:  prdata <= {18'h00000, mr3};
        default:   prdata <= '0;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr != CTRL_ADDR) & (paddr != STAT_ADDR)
                   & (paddr != MR1_ADDR) & (paddr != MR3_ADDR);

  a_wl_enter: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE1]
    cmd_mrs && ba_s == BA_MR1 |=> wl_mode == $past(addr_s[MR1_WL]))
    else $error("leveling mode did not follow MR1 A7");

  a_qoff_oe: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE2]
    mr1[MR1_QOFF] |=> !dq_oe[0] && !dq_oe[1])
    else $error("outputs driven while disabled");

  a_dq_term: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE3]
    wl_mode && $past(wl_mode) |-> !data_term_on)
    else $error("data termination on in leveling");

  a_odt_wait: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE8] [RULE9]
    wl_mode && mod_busy ##1 wl_mode |-> strobe_term_on == 2'h0)
    else $error("ODT honoured before mode delay");

  a_fb_hold: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE11] [RULE26]
    wl_mode && strb_s[0] && !strb_d[0] ##1 wl_mode && !(strb_s[0] && !strb_d[0])
    |=> fb[0] == $past(ck_s, 2))
    else $error("captured CK level lost");

  a_lane_split: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE13]
    wl_mode && !(strb_s[1] && !strb_d[1]) && $past(wl_mode) |=> $stable(fb[1]))
    else $error("upper feedback moved without its strobe");

  a_prime_low: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE12]
    $past(wl_mode) && !$past(ctrl[CTRL_FB_ALL]) |-> dq_q[0][7:1] == 7'h00)
    else $error("non-prime bits not low");

  a_mpr_start: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE18]
    state == DWL_IDLE && cmd_rd && mpr_en |=> state == DWL_WAIT ##[1:200] state == DWL_BURST)
    else $error("calibration read not served");

  a_mpr_data: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE24]
    state == DWL_BURST && mr3[1:0] == LOC_PAT |=> mpr_bit == $past(beat[0]))
    else $error("calibration pattern wrong");

  a_copy_bits: assert property (@(posedge ref_clk) disable iff (!rst_s_n)  // [RULE21]
    !wl_mode && state == DWL_BURST && ctrl[CTRL_COPY] |=> dq_q[1] == {8{$past(mpr_bit)}})
    else $error("copy bits differ from bit 0");
endmodule : dwl_training

/* hdl/dwl_pkg.sv */
package dwl_pkg;
  // Core clock and derived delays
  localparam int unsigned CLK_MHZ  = 100;
  localparam int unsigned TWLO_NS  = 9;
  localparam int unsigned TWLO_RAW = TWLO_NS * CLK_MHZ / 1000;
  localparam int unsigned TWLO_CYC = (TWLO_RAW < 1) ? 1 : TWLO_RAW;
  localparam logic [4:0]  TMOD_CK  = 5'h0C;  // Mode register delay, CK cycles

  // APB register map
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STAT_ADDR = 12'h004;
  localparam logic [11:0] MR1_ADDR  = 12'h008;
  localparam logic [11:0] MR3_ADDR  = 12'h00C;

  // Control register fields
  localparam int unsigned CTRL_FB_ALL = 0;
  localparam int unsigned CTRL_COPY   = 1;
  localparam int unsigned CTRL_RL_LSB = 4;
  localparam logic [7:0]  CTRL_RST    = 8'h60;  // Read latency 6

  // Status register fields
  localparam int unsigned ST_WL   = 0;
  localparam int unsigned ST_QOFF = 1;
  localparam int unsigned ST_MPR  = 2;
  localparam int unsigned ST_ODT  = 3;
  localparam int unsigned ST_FB0  = 4;
  localparam int unsigned ST_FB1  = 5;
  localparam int unsigned ST_ILL  = 6;
  localparam int unsigned ST_BUSY = 7;

  // Mode register bit positions and bank codes
  localparam int unsigned MR1_WL   = 7;
  localparam int unsigned MR1_QOFF = 12;
  localparam int unsigned MR3_MPR  = 2;
  localparam int unsigned ADDR_BC  = 12;
  localparam logic [2:0]  BA_MR0   = 3'h0;
  localparam logic [2:0]  BA_MR1   = 3'h1;
  localparam logic [2:0]  BA_MR3   = 3'h3;
  localparam logic [1:0]  BL_FIX8  = 2'h0;
  localparam logic [1:0]  BL_OTF   = 2'h1;
  localparam logic [1:0]  BL_BC4   = 2'h2;
  localparam logic [1:0]  LOC_PAT  = 2'h0;
  localparam logic [3:0]  BEATS8   = 4'h8;
  localparam logic [3:0]  BEATS4   = 4'h4;

  // Command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;

  typedef enum logic [1:0] {
    DWL_IDLE  = 2'h0,
    DWL_WAIT  = 2'h1,
    DWL_BURST = 2'h3
  } dwl_state_t;
endpackage : dwl_pkg

/* hdl/dwl_sync.sv */
`timescale 1ns/1ns
module dwl_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // Two stages; the first is read by the second only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : dwl_sync

/* testbench/dwl_ctrl_model.sv */
`timescale 1ns/1ns
module dwl_ctrl_model (
  input  wire logic   ref_clk,
  output logic        ck,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [13:0] addr,
  output logic        odt,
  output logic [1:0]  strobe
);
  // Idle pins, then a free-running CK with its own phase
  initial begin
    {cs_n, ras_n, cas_n, we_n, ba, addr, odt, strobe} = {4'hF, 17'h0, 1'b0, 2'h0};
    ck = 1'b0;
    #7;
    forever begin
      #62 ck = 1'b1;
      #63 ck = 1'b0;
    end
  end

  // Held across one whole CK rise; lines scrambled once deselected
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(negedge ck);
    @(posedge ref_clk);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= ~c;
    ba <= ~b;
    addr <= ~a;
  endtask : cmd

  task automatic set_odt(input logic v);
    @(posedge ref_clk);
    odt <= v;
  endtask : set_odt

  // Strobe delay stepped by picking the CK phase of the edge
  task automatic pulse(input int lane, input logic hi);
    if (hi) @(posedge ck);
    else @(negedge ck);
    repeat (2) @(posedge ref_clk);
    strobe[lane[0]] <= 1'b1;  // Single rising edge
    repeat (5) @(posedge ref_clk);
    strobe[lane[0]] <= 1'b0;
  endtask : pulse
endmodule : dwl_ctrl_model

/* testbench/tb_dwl_training.sv */
`timescale 1ns/1ns
module tb_dwl_training;
  import dwl_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ck, cs_n, ras_n, cas_n, we_n, odt, lo_oe, up_oe, data_term_on;
  logic [2:0]  ba;
  logic [13:0] addr, a;
  logic [1:0]  strobe, strobe_term_on, fb;
  logic [7:0]  lo_dq, up_dq, seq;
  logic [3:0]  rl;
  logic        hi, copy, in_mpr, chop;
  int          bad_count, n_compared, runs, oe_cyc, i, j, lane, mode;
  time         t_cmd, t_oe;

  dwl_training dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .odt(odt), .lower_lane_strobe_pair(strobe[0]),
    .upper_lane_strobe_pair(strobe[1]), .lower_byte_data_lines(lo_dq),
    .lower_byte_data_oe(lo_oe), .upper_byte_data_lines(up_dq), .upper_byte_data_oe(up_oe),
    .strobe_term_on(strobe_term_on), .data_term_on(data_term_on));
  dwl_ctrl_model m (.ref_clk(ref_clk), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .odt(odt), .strobe(strobe));

  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // One APB transfer; the slave decides when it is done
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_ck(input int n);
    repeat (n) @(posedge ck);
    @(negedge ref_clk);
  endtask : wait_ck

  // Burst capture: run-length of bit 0, lane copies checked every cycle
  always @(posedge ck) if (cs_n === 1'b0) t_cmd = $time;
  always @(negedge ref_clk) begin
    if (in_mpr && lo_oe === 1'b1) begin
      if (oe_cyc == 0) t_oe = $time;
      if (oe_cyc == 0 || lo_dq[0] !== seq[0]) begin
        seq = {seq[6:0], lo_dq[0]};
        runs++;
      end
      oe_cyc++;
      check({up_dq, lo_dq[7:1]}, {copy ? {7{lo_dq[0]}} : 7'h0, lo_dq[0],
        copy ? {7{lo_dq[0]}} : 7'h0});
    end
  end

  task automatic mpr_read(input logic [13:0] ad, input int beats, input logic pat);
    runs = 0;
    oe_cyc = 0;
    seq = 8'h00;
    in_mpr = 1'b1;
    m.cmd(CMD_RD, 3'($urandom), ad);
    j = 0;
    while (lo_oe !== 1'b1 && j < 400) begin @(negedge ref_clk); j++; end
    while (lo_oe === 1'b1 && j < 400) begin @(negedge ref_clk); j++; end
    in_mpr = 1'b0;
    check(32'(runs), pat ? 32'(beats) : 32'h1);
    check(32'(seq), pat ? (beats == 8 ? 32'h55 : 32'h05) : 32'h0);
    check(32'(oe_cyc > beats * 6 - 3 && oe_cyc < beats * 6 + beats / 2 + 3), 32'h1);
    check(32'(t_oe - t_cmd >= rl * 125 - 10 && t_oe - t_cmd <= rl * 125 + 90), 32'h1);
    wait_ck(4);
  endtask : mpr_read

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, in_mpr, copy} = '0;
    bad_count = 0;
    n_compared = 0;
    rl = 4'h6;
    fb = 2'b00;
    void'($urandom(32'h5bd5));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge ref_clk);
    // Reset state and an unmapped address
    check({lo_oe, up_oe, strobe_term_on, data_term_on}, 32'h0);
    apb(1'b0, CTRL_ADDR, 32'h0);
    check(rd, 32'(CTRL_RST));
    apb(1'b0, STAT_ADDR, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, err}, 32'h1);
    // Enter leveling; ODT raised too early must be ignored
    m.cmd(CMD_MRS, BA_MR1, 14'h0080);
    m.set_odt(1'b1);
    repeat (8) @(negedge ref_clk);
    check(32'(strobe_term_on), 32'h0);
    wait_ck(13);
    check({strobe_term_on, data_term_on, lo_oe, up_oe}, 32'h1B);
    // Random strobe phases on random lanes; the other lane must keep its level
    for (i = 0; i < 14; i++) begin
      if (i == 7) apb(1'b1, CTRL_ADDR, 32'h61);
      lane = $urandom % 2;
      hi = 1'($urandom);
      fb[lane] = hi;
      m.pulse(lane, hi);
      repeat (12) @(negedge ref_clk);
      check({up_dq, lo_dq}, {i >= 7 ? {7{fb[1]}} : 7'h0, fb[1],
        i >= 7 ? {7{fb[0]}} : 7'h0, fb[0]});
    end
    // Output disable and re-enable inside leveling
    m.cmd(CMD_MRS, BA_MR1, 14'h1080);
    wait_ck(2);
    check({lo_oe, up_oe}, 32'h0);
    apb(1'b0, STAT_ADDR, 32'h0);
    check(32'(rd[ST_QOFF]), 32'h1);
    check(32'(rd[ST_ODT]), 32'h1);
    check(32'(rd[ST_FB1:ST_FB0]), 32'(fb));
    m.cmd(CMD_MRS, BA_MR1, 14'h0080);
    wait_ck(2);
    check({lo_oe, up_oe}, 32'h3);
    check(32'(strobe_term_on), 32'h3);
    // Exit: ODT off first, then MR1 with other fields changed
    m.set_odt(1'b0);
    repeat (10) @(negedge ref_clk);
    check(32'(strobe_term_on), 32'h0);
    m.cmd(CMD_MRS, BA_MR1, 14'h0266);
    wait_ck(13);
    check({lo_oe, up_oe}, 32'h0);
    apb(1'b0, MR1_ADDR, 32'h0);
    check(32'(rd[13:0]), 32'h266);
    apb(1'b0, STAT_ADDR, 32'h0);
    check(32'(rd[ST_WL]), 32'h0);
    // Calibration register across latencies and burst modes
    m.cmd(CMD_MRS, BA_MR3, 14'h0004);
    wait_ck(13);
    apb(1'b0, STAT_ADDR, 32'h0);
    check(32'(rd[ST_MPR]), 32'h1);
    for (i = 0; i < 7; i++) begin
      rl = 4'(5 + $urandom % 7);
      copy = 1'($urandom);
      apb(1'b1, CTRL_ADDR, {24'h0, rl, 2'b00, copy, 1'b0});
      apb(1'b0, CTRL_ADDR, 32'h0);
      check(rd, {24'h0, rl, 2'b00, copy, 1'b0});
      mode = i % 3;
      m.cmd(CMD_MRS, BA_MR0, {12'h0, 2'(mode)});
      wait_ck(13);
      chop = (mode == 2) || (mode == 1 && i > 3);
      a = 14'($urandom);  // Bank, A10 and spare column bits random
      a[1:0] = 2'b00;
      a[2] = chop ? 1'($urandom) : 1'b0;
      if (mode == 1) a[12] = ~chop;
      mpr_read(a, chop ? 4 : 8, 1'b1);
    end
    // Reserved location reads as zero
    m.cmd(CMD_MRS, BA_MR3, 14'h0005);
    wait_ck(13);
    mpr_read(14'h0000, 8, 1'b0);  // Last MR0 write left BL8
    // Any command other than read, MRS or NOP is flagged; write one clears the flag
    m.cmd(3'h3, 3'h0, 14'h0000);
    wait_ck(2);
    apb(1'b0, STAT_ADDR, 32'h0);
    check(32'(rd[ST_ILL]), 32'h1);
    apb(1'b1, STAT_ADDR, 32'h40);
    apb(1'b0, STAT_ADDR, 32'h0);
    check(32'(rd[ST_ILL]), 32'h0);
    wait_ck(4);
    m.cmd(CMD_MRS, BA_MR3, 14'h0000);
    wait_ck(13);
    apb(1'b0, STAT_ADDR, 32'h0);
    check(32'(rd[ST_MPR]), 32'h0);
    print_verdict();
  end

  // Watchdog well beyond the expected run
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
endmodule : tb_dwl_training
